// ==== shared/pwcc_pkg.sv ====
package pwcc_pkg;
  // ==========================================
  // Control field and modes
  localparam int CTRL_W = 16;
  localparam int WMODE_LSB = 8;
  localparam int WMODE_MSB = 9;
  localparam logic [1:0] WMODE_OFF = 2'h0;
  localparam logic [1:0] WMODE_INHIBIT_IN = 2'h1;
  localparam logic [1:0] WMODE_INT_OUT = 2'h2;
  localparam logic [1:0] WMODE_CLIP = 2'h3;
  // ==========================================
  // XY address layout
  localparam int XY_W = 32;
  localparam int COORD_W = 16;
  localparam int Y_LSB = 16;
  localparam int X_LSB = 0;
  // ==========================================
  // Point compare code bits, and reset values
  localparam int CODE_W = 4;
  localparam int CODE_LEFT = 0;
  localparam int CODE_RIGHT = 1;
  localparam int CODE_ABOVE = 2;
  localparam int CODE_BELOW = 3;
  localparam logic [CODE_W-1:0] CODE_RESET = 4'h0;
  localparam logic [XY_W-1:0] CORNER_RESET = 32'h0000_0000;
  localparam logic [1:0] WMODE_RESET = 2'h0;
endpackage

// ==== hw/pwcc_corner_store.sv ====
`timescale 1ns/1ps
module pwcc_corner_store #(
  parameter int WIDTH = 32
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_we_start,
  input wire logic i_we_end,
  input wire logic [WIDTH-1:0] i_data,
  output logic [WIDTH-1:0] o_start,
  output logic [WIDTH-1:0] o_end
);
  logic [WIDTH-1:0] start_r;
  logic [WIDTH-1:0] start_nxt;
  logic [WIDTH-1:0] end_r;
  logic [WIDTH-1:0] end_nxt;

  always_comb begin
    start_nxt = i_we_start ? i_data : start_r;
    end_nxt = i_we_end ? i_data : end_r;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      start_r <= '0;
      end_r <= '0;
    end else begin
      start_r <= start_nxt;
      end_r <= end_nxt;
    end
  end

  assign o_start = start_r;
  assign o_end = end_r;
endmodule

// ==== hw/pwcc_top.sv ====
`timescale 1ns/1ps
// Operation
// - Mode from control bits 8 and 9
// - Four modes: allow, inhibit-in, int-out, clip
// - Start corner is upper left
// - End corner is lower right
// - Both corners lie inside window
// - Int-out mode: crossing op not executed
// - Compare point gives position code
module pwcc_top (
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  // Control and corner loads
  input wire logic [pwcc_pkg::CTRL_W-1:0] I_CONTROL,
  input wire logic I_START_WE,
  input wire logic I_END_WE,
  input wire logic [pwcc_pkg::XY_W-1:0] I_CORNER_DATA,
  // Pixel write request from drawing engine
  input wire logic I_PIX_VALID,
  input wire logic [pwcc_pkg::XY_W-1:0] I_PIX_XY,
  // Operation boundary check request
  input wire logic I_OP_VALID,
  input wire logic [pwcc_pkg::XY_W-1:0] I_OP_START_XY,
  input wire logic [pwcc_pkg::XY_W-1:0] I_OP_END_XY,
  // Point compare request
  input wire logic I_CMP_VALID,
  input wire logic [pwcc_pkg::XY_W-1:0] I_CMP_XY,
  // Pixel write answer
  output logic O_PIX_DONE,
  output logic O_PIX_WRITE,
  output logic O_PIX_INT,
  // Operation answer
  output logic O_OP_DONE,
  output logic O_OP_EXEC,
  output logic O_OP_INT,
  // Point compare answer
  output logic O_CMP_DONE,
  output logic [pwcc_pkg::CODE_W-1:0] O_CMP_CODE,
  // Current mode
  output logic [1:0] O_WMODE
);
  import pwcc_pkg::*;

  // ==========================================
  // Helpers
  function automatic logic [COORD_W-1:0] y_of(input logic [XY_W-1:0] a);
    y_of = a[Y_LSB +: COORD_W];
  endfunction

  function automatic logic [COORD_W-1:0] x_of(input logic [XY_W-1:0] a);
    x_of = a[X_LSB +: COORD_W];
  endfunction

  function automatic logic [CODE_W-1:0] where_is(input logic [XY_W-1:0] p,
      input logic [XY_W-1:0] ws, input logic [XY_W-1:0] we);
    logic [CODE_W-1:0] c;
    c = '0;
    c[CODE_LEFT] = x_of(p) < x_of(ws);
    c[CODE_ABOVE] = y_of(p) < y_of(ws);
    c[CODE_RIGHT] = x_of(p) > x_of(we);
    c[CODE_BELOW] = y_of(p) > y_of(we);
    where_is = c;
  endfunction

  // ==========================================
  // Corner storage
  logic [XY_W-1:0] window_start_corner;
  logic [XY_W-1:0] window_end_corner;

  pwcc_corner_store #(.WIDTH(XY_W)) u_corners (
    .i_clk(I_CLOCK),
    .i_rst(I_RESET),
    .i_we_start(I_START_WE),
    .i_we_end(I_END_WE),
    .i_data(I_CORNER_DATA),
    .o_start(window_start_corner),
    .o_end(window_end_corner)
  );

  // ==========================================
  // Decision logic
  logic [1:0] mode;
  logic pix_in;
  logic op_in;
  logic pix_done_r, pix_done_nxt;
  logic pix_write_r, pix_write_nxt;
  logic pix_int_r, pix_int_nxt;
  logic op_done_r, op_done_nxt;
  logic op_exec_r, op_exec_nxt;
  logic op_int_r, op_int_nxt;
  logic cmp_done_r, cmp_done_nxt;
  logic [CODE_W-1:0] cmp_code_r, cmp_code_nxt;
  logic [1:0] wmode_r, wmode_nxt;

  always_comb begin
    mode = I_CONTROL[WMODE_MSB:WMODE_LSB];
    pix_in = where_is(I_PIX_XY, window_start_corner, window_end_corner) == '0;
    op_in = (where_is(I_OP_START_XY, window_start_corner, window_end_corner) == '0) &&
            (where_is(I_OP_END_XY, window_start_corner, window_end_corner) == '0);
    wmode_nxt = mode;
    pix_done_nxt = I_PIX_VALID;
    pix_write_nxt = 1'b0;
    pix_int_nxt = 1'b0;
    op_done_nxt = I_OP_VALID;
    op_exec_nxt = 1'b0;
    op_int_nxt = 1'b0;
    if (I_PIX_VALID) begin
      case (mode)
        WMODE_OFF: begin
          pix_write_nxt = 1'b1;
        end
        WMODE_INHIBIT_IN: begin
          pix_write_nxt = !pix_in;
          pix_int_nxt = pix_in;
        end
        WMODE_INT_OUT: begin
          pix_write_nxt = pix_in;
          pix_int_nxt = !pix_in;
        end
        WMODE_CLIP: begin
          pix_write_nxt = pix_in;
        end
        default: begin
          pix_write_nxt = 1'b0;
        end
      endcase
    end
    if (I_OP_VALID) begin
      case (mode)
        WMODE_INT_OUT: begin
          op_exec_nxt = op_in;
          op_int_nxt = !op_in;
        end
        default: begin
          op_exec_nxt = 1'b1;
        end
      endcase
    end
    cmp_done_nxt = I_CMP_VALID;
    cmp_code_nxt = I_CMP_VALID ? where_is(I_CMP_XY, window_start_corner, window_end_corner) : cmp_code_r;
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      wmode_r <= WMODE_RESET;
      pix_done_r <= 1'b0;
      pix_write_r <= 1'b0;
      pix_int_r <= 1'b0;
      op_done_r <= 1'b0;
      op_exec_r <= 1'b0;
      op_int_r <= 1'b0;
      cmp_done_r <= 1'b0;
      cmp_code_r <= CODE_RESET;
    end else begin
      wmode_r <= wmode_nxt;
      pix_done_r <= pix_done_nxt;
      pix_write_r <= pix_write_nxt;
      pix_int_r <= pix_int_nxt;
      op_done_r <= op_done_nxt;
      op_exec_r <= op_exec_nxt;
      op_int_r <= op_int_nxt;
      cmp_done_r <= cmp_done_nxt;
      cmp_code_r <= cmp_code_nxt;
    end
  end

  assign O_WMODE = wmode_r;
  assign O_PIX_DONE = pix_done_r;
  assign O_PIX_WRITE = pix_write_r;
  assign O_PIX_INT = pix_int_r;
  assign O_OP_DONE = op_done_r;
  assign O_OP_EXEC = op_exec_r;
  assign O_OP_INT = op_int_r;
  assign O_CMP_DONE = cmp_done_r;
  assign O_CMP_CODE = cmp_code_r;

  // ==========================================
  // Checks
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);

  sequence s_pix_off;
    I_PIX_VALID && I_CONTROL[WMODE_MSB:WMODE_LSB] == WMODE_OFF;
  endsequence

  a_mode_follows: assert property (##1 O_WMODE == $past(I_CONTROL[WMODE_MSB:WMODE_LSB]))
    else $error("mode not taken from control bits");
  a_off_writes: assert property (s_pix_off |=> O_PIX_DONE && O_PIX_WRITE && !O_PIX_INT)
    else $error("mode off blocked a write");
  a_clip_silent: assert property (I_CONTROL[WMODE_MSB:WMODE_LSB] == WMODE_CLIP |=> !O_PIX_INT)
    else $error("clip mode raised interrupt");
  a_inhibit_in: assert property (I_PIX_VALID && I_CONTROL[WMODE_MSB:WMODE_LSB] == WMODE_INHIBIT_IN
      && y_of(window_start_corner) <= y_of(window_end_corner) && x_of(window_start_corner) <= x_of(window_end_corner)
      && I_PIX_XY == window_start_corner && !I_START_WE |=> !O_PIX_WRITE && O_PIX_INT)
    else $error("start corner write not inhibited");
  a_end_inside: assert property (I_PIX_VALID && I_CONTROL[WMODE_MSB:WMODE_LSB] == WMODE_CLIP
      && y_of(window_start_corner) <= y_of(window_end_corner) && x_of(window_start_corner) <= x_of(window_end_corner)
      && I_PIX_XY == window_end_corner |=> O_PIX_WRITE)
    else $error("end corner clipped");
  a_int_excl: assert property (O_PIX_INT |-> !O_PIX_WRITE && O_PIX_DONE)
    else $error("interrupt with write");
  a_op_block: assert property (O_OP_INT |-> !O_OP_EXEC && $past(mode) == WMODE_INT_OUT)
    else $error("crossing operation executed");
  a_cmp_code: assert property (I_CMP_VALID && I_CMP_XY == window_start_corner && !I_START_WE
      |=> O_CMP_DONE && O_CMP_CODE[CODE_LEFT] == 1'b0 && O_CMP_CODE[CODE_ABOVE] == 1'b0)
    else $error("compare code wrong at start corner");
  a_y_upper: assert property (I_CMP_VALID && I_CMP_XY[31:16] < window_start_corner[31:16]
      |=> O_CMP_CODE[CODE_ABOVE])
    else $error("Y not taken from upper half");
endmodule

// ==== test/pwcc_engine.sv ====
`timescale 1ns/1ps
// ==========
// Drawing engine issuing pixel writes
module pwcc_engine (
  // Clock
  input wire logic i_clk,
  // Request
  output logic o_valid,
  output logic [pwcc_pkg::XY_W-1:0] o_xy,
  // Answer
  input wire logic i_done,
  input wire logic i_write,
  input wire logic i_int
);
  import pwcc_pkg::*;
  initial begin
    o_valid = 1'b0;
    o_xy = 32'h0;
  end
  task automatic pix(input logic [XY_W-1:0] xy, output logic w, output logic ir,
      output bit ok);
    ok = 1'b0;
    @(negedge i_clk);
    o_valid = 1'b1;
    o_xy = xy;
    // Answer stands in the cycle after the taking edge
    for (int n = 0; n < 4 && !ok; n++) begin
      @(negedge i_clk);
      o_valid = 1'b0;
      // Released address never shows the old value
      o_xy = ~xy;
      ok = (i_done === 1'b1);
      w = i_write;
      ir = i_int;
    end
  endtask
endmodule

// ==== test/pwcc_top_tb.sv ====
`timescale 1ns/1ps
module pwcc_top_tb;
  import pwcc_pkg::*;
  localparam logic [31:0] WS = 32'h0040_0058;
  localparam logic [31:0] WE = 32'h004C_00A9;
  logic I_CLOCK, I_RESET, I_START_WE, I_END_WE, I_OP_VALID, I_CMP_VALID, pv;
  logic [15:0] I_CONTROL;
  logic [31:0] I_CORNER_DATA, I_OP_START_XY, I_OP_END_XY, I_CMP_XY, pxy;
  logic pd, pw, pi, od, oe, oi, cd;
  logic [3:0] cc;
  logic [1:0] wm;
  logic [31:0] pts [7] = '{32'h0040_0058, 32'h004C_00A9, 32'h0040_0057, 32'h004C_00AA,
      32'h003F_0060, 32'h004D_0060, 32'h0045_0070};
  int miscompares = 0;
  int checks = 0;
  pwcc_top DUT (.I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .I_CONTROL(I_CONTROL),
    .I_START_WE(I_START_WE), .I_END_WE(I_END_WE), .I_CORNER_DATA(I_CORNER_DATA),
    .I_PIX_VALID(pv), .I_PIX_XY(pxy), .I_OP_VALID(I_OP_VALID),
    .I_OP_START_XY(I_OP_START_XY), .I_OP_END_XY(I_OP_END_XY), .I_CMP_VALID(I_CMP_VALID),
    .I_CMP_XY(I_CMP_XY), .O_PIX_DONE(pd), .O_PIX_WRITE(pw), .O_PIX_INT(pi),
    .O_OP_DONE(od), .O_OP_EXEC(oe), .O_OP_INT(oi), .O_CMP_DONE(cd), .O_CMP_CODE(cc),
    .O_WMODE(wm));
  pwcc_engine eng (.i_clk(I_CLOCK), .o_valid(pv), .o_xy(pxy), .i_done(pd),
    .i_write(pw), .i_int(pi));
  // ==========
  // Checking helpers
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wt(input bit op);
    bit ok;
    ok = 1'b0;
    for (int n = 0; n < 4 && !ok; n++) begin
      ok = ((op ? od : cd) === 1'b1);
      if (!ok)
        @(negedge I_CLOCK);
    end
    chk("done", ok, 1);
    if (!ok)
      stop_test();
  endtask
  function automatic logic inw(logic [31:0] p);
    return p[31:16] >= WS[31:16] && p[31:16] <= WE[31:16] && p[15:0] >= WS[15:0]
      && p[15:0] <= WE[15:0];
  endfunction
  task automatic set_mode(logic [1:0] m);
    @(negedge I_CLOCK);
    I_CONTROL = 16'hFCFF | (16'(m) << WMODE_LSB);
    repeat (2) @(negedge I_CLOCK);
    chk("wmode", wm, m);
  endtask
  // ==========
  // Scenarios
  task automatic t_pix();
    logic w, ir;
    bit ok;
    for (int m = 0; m < 4; m++) begin
      set_mode(m[1:0]);
      foreach (pts[k]) begin
        eng.pix(pts[k], w, ir, ok);
        chk("pix_done", ok, 1);
        if (!ok)
          stop_test();
        chk("write", w, m == 0 || (m == 1) != inw(pts[k]));
        chk("int", ir, (m == 1 && inw(pts[k])) || (m == 2 && !inw(pts[k])));
      end
    end
  endtask
  task automatic t_op();
    logic x;
    for (int m = 0; m < 4; m++) begin
      set_mode(m[1:0]);
      for (int k = 1; k < 7; k++) begin
        @(negedge I_CLOCK);
        I_OP_VALID = 1'b1;
        I_OP_START_XY = pts[0];
        I_OP_END_XY = pts[k];
        @(negedge I_CLOCK);
        I_OP_VALID = 1'b0;
        wt(1'b1);
        x = !(m == 2 && !inw(pts[k]));
        chk("exec", oe, x);
        chk("op_int", oi, !x);
      end
    end
  endtask
  task automatic t_cmp();
    logic [3:0] e;
    foreach (pts[k]) begin
      @(negedge I_CLOCK);
      I_CMP_VALID = 1'b1;
      I_CMP_XY = pts[k];
      @(negedge I_CLOCK);
      I_CMP_VALID = 1'b0;
      I_CMP_XY = ~pts[k];
      wt(1'b0);
      e = {pts[k][31:16] > WE[31:16], pts[k][31:16] < WS[31:16],
        pts[k][15:0] > WE[15:0], pts[k][15:0] < WS[15:0]};
      chk("code", cc, e);
      repeat (3) @(negedge I_CLOCK);
      chk("code_held", cc, e);
    end
  endtask
  initial begin
    I_CLOCK = 1'b0;
    forever #5 I_CLOCK = ~I_CLOCK;
  end
  initial begin
    I_RESET = 1'b1;
    {I_START_WE, I_END_WE, I_OP_VALID, I_CMP_VALID, I_CONTROL} = '0;
    {I_CORNER_DATA, I_OP_START_XY, I_OP_END_XY, I_CMP_XY} = '0;
    repeat (10) @(negedge I_CLOCK);
    I_RESET = 1'b0;
    chk("reset_done", pd, 0);
    I_START_WE = 1'b1;
    I_CORNER_DATA = WS;
    @(negedge I_CLOCK);
    I_START_WE = 1'b0;
    I_END_WE = 1'b1;
    I_CORNER_DATA = WE;
    @(negedge I_CLOCK);
    I_END_WE = 1'b0;
    I_CORNER_DATA = ~WE;
    t_pix();
    t_op();
    t_cmp();
    stop_test();
  end
endmodule
